// File: ost_check_props.sv
// checker for the oscillator select and tune block
`timescale 1ns/1ps
module ost_check_props (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic waitExec,
    input wire ost_pkg::ost_clk_t clkOut,
    input wire logic enterSleep,
    input wire logic enterIdle
);
    import ost_pkg::*;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    // access phase decode shared by the bus checks
    logic acc;
    logic rdCtl;
    assign acc = psel && penable;
    assign rdCtl = acc && !pwrite && paddr == 12'h000;
    a_bad_addr_err: assert property (acc && paddr[11:5] != 0 |-> pslverr)
        else $error("no error on unmapped access");
    a_bad_addr_zero: assert property (
        acc && !pwrite && paddr[11:5] != 0 |-> prdata == 32'h0)
        else $error("unmapped read not zero");
    a_tune_resvd: assert property (
        acc && !pwrite && paddr[11:4] == 8'h01 |-> prdata[31:6] == 0)
        else $error("tuning spare bits set");
    a_ctl_resvd: assert property (
        rdCtl |-> (prdata & 32'hc0808800) == 32'h0)
        else $error("control spare bits set");
    a_out_div: assert property (
        $onehot(clkOut.pllOutDivide) && clkOut.pllOutDivide != 9'h080)
        else $error("bad pll out divide");
    a_rc_div: assert property (
        $onehot(clkOut.rcDivide) && clkOut.rcDivide != 9'h080)
        else $error("bad rc divide");
    a_pb_div: assert property ($onehot(clkOut.periphDivide))
        else $error("bad periph divide");
    a_mul_set: assert property (
        clkOut.pllMultiply inside {[5'h0f:5'h15], 5'h18})
        else $error("bad pll multiply");
    // tune output may only move after a tuning write lands
    a_tune_hold: assert property (
        $changed(clkOut.rcTune) |->
        $past(acc && pwrite && paddr[11:4] == 8'h01))
        else $error("tune moved without write");
    a_wait_mode: assert property (
        (enterSleep || enterIdle) == waitExec && !(enterSleep && enterIdle))
        else $error("wait mode outputs wrong");
    a_sosc_ready: assert property (
        rdCtl && prdata[22] |-> clkOut.soscEnable)
        else $error("ready while oscillator off");
    c_err: cover property (acc && pslverr);
    c_src: cover property ($changed(clkOut.source));
    c_sleep: cover property (enterSleep);
endmodule : ost_check_props

bind ost_oscillator_select_and_tune ost_check_props i_ost_check_props (
    .core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .waitExec(waitExec), .clkOut(clkOut),
    .enterSleep(enterSleep), .enterIdle(enterIdle));

// File: ost_oscillator_select_and_tune.sv
// oscillator select and tune register block with apb slave
// Notes on behaviour
// - out divider codes 0..7 divide pll output by 1,2,4,8,16,32,64,256.
// - rc divider codes divide fast rc likewise; reset code 001.
// - secondary ready flag high only while that oscillator runs stable.
// - divisor-ready flag says whether the periph divisor may be written.
// - periph divisor codes divide system clock by 1,2,4,8; reset 11.
// - pll multiplier codes give 15,16,17,18,19,20,21,24.
// - current-source field reports the running oscillator encoding.
// - new-source field same encoding, loaded from boot config at reset.
// - with monitor config 1x, lock bit freezes clock and pll selections.
// - with monitor config 0x, selections never lock.
// - usb pll locked flag follows lock or start timer expiry.
// - system pll locked flag follows lock or start timer expiry.
// - sleep-on-wait bit picks sleep, else idle, for wait instruction.
// - clock-fail flag reads one once a failure is detected.
// - usb rc select bit routes fast rc as usb clock.
// - secondary enable bit switches that oscillator on or off.
// - software sets switch request; device clears it when done.
// - six-bit tune value is a signed offset around centre frequency.
// - unimplemented bits read zero and ignore writes.
// - clear, set and invert aliases at plus 0x4, 0x8, 0xc.
//
// Implementation choices: the address map and register access over APB.
`timescale 1ns/1ps
module ost_oscillator_select_and_tune (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic clkEn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire ost_pkg::ost_cfg_t cfgIn,
    input wire ost_pkg::ost_stat_t statIn,
    input wire logic waitExec,
    output ost_pkg::ost_clk_t clkOut,
    output logic enterSleep,
    output logic enterIdle
);
    import ost_pkg::*;

    typedef enum logic [1:0] {
        SW_IDLE,
        SW_WAIT,
        SW_SETTLE
    } ost_sw_t;

    // divider and multiplier decode, used for both dividers
    function automatic logic [8:0] divFactor(input logic [2:0] code);
        logic [8:0] f;
        f = 9'h001;
        if (code == 3'h7) begin
            f = 9'h100;
        end else begin
            f = 9'(9'h001 << code);
        end
        return f;
    endfunction : divFactor

    function automatic logic [4:0] mulFactor(input logic [2:0] code);
        logic [4:0] m;
        m = 5'(5'h0f + 5'(code));
        if (code == 3'h7) begin
            m = 5'h18;
        end
        return m;
    endfunction : mulFactor

    // register select decode; an alias shares the base of its register
    function automatic logic hitsReg(input logic [11:0] a,
                                     input logic [11:0] ofs);
        logic h;
        h = ({a[11:4], 4'h0} == ofs);
        return h;
    endfunction : hitsReg

    // decoded image of the register reset values, before straps load
    localparam ost_clk_t CLK_RST = '{
        pllOutDivide: divFactor('0),
        rcDivide: divFactor(RST_RC_DIV),
        periphDivide: 4'(4'h1 << RST_PB_DIV),
        pllMultiply: mulFactor('0),
        source: SRC_FRC,
        usbRcSelect: 1'b0,
        soscEnable: 1'b0,
        rcTune: RST_TUNE
    };

    // three-stage synchronisers for the analog status inputs
    localparam int STAT_W = $bits(ost_stat_t);
    logic [STAT_W-1:0] syncA_q, syncB_q, syncC_q, stat_q;
    logic [STAT_W-1:0] stat_d;
    genvar gi;
    generate
        for (gi = 0; gi < STAT_W; gi++) begin : gStat
            // a change counts once the second and third stages agree
            always_comb begin
                stat_d[gi] = stat_q[gi];
                if (syncB_q[gi] == syncC_q[gi]) begin
                    stat_d[gi] = syncC_q[gi];
                end
            end
        end
    endgenerate

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            syncA_q <= '0;
            syncB_q <= '0;
            syncC_q <= '0;
            stat_q <= '0;
        end else if (clkEn) begin
            syncA_q <= statIn;
            syncB_q <= syncA_q;
            syncC_q <= syncB_q;
            stat_q <= stat_d;
        end
    end
    ost_stat_t st;
    assign st = ost_stat_t'(stat_q);

    // configuration straps captured on the first enabled edge after reset
    logic loaded_q, loaded_d;
    ost_cfg_t cfg_q, cfg_d;
    // straps are held once taken, so a strap pin that moves later is ignored
    always_comb begin
        loaded_d = 1'b1;
        cfg_d = loaded_q ? cfg_q : cfgIn;
    end
    // strap capture register
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            loaded_q <= 1'b0;
            cfg_q <= '0;
        end else if (clkEn) begin
            loaded_q <= loaded_d;
            cfg_q <= cfg_d;
        end
    end

    // register state
    logic [2:0] outDiv_q, outDiv_d, rcDiv_q, rcDiv_d, pllMul_q, pllMul_d;
    logic [1:0] periph_clock_divisor_q, periph_clock_divisor_d;
    ost_src_t curSrc_q, curSrc_d;
    logic [2:0] newSrc_q, newSrc_d;
    logic lock_q, lock_d, sleep_q, sleep_d, usbRc_q, usbRc_d;
    logic secondary_osc_enable_q, secondary_osc_enable_d, swReq_q, swReq_d, fail_q, fail_d;
    logic [TUNE_W-1:0] tune_q, tune_d;
    ost_sw_t sw_q, sw_d;
    logic [3:0] settle_q, settle_d;

    // apb decode; one wait-free access phase
    logic wrEn, frozen, divReady;
    logic hitCtl, hitTun;
    logic [3:0] aliasSel;
    logic [31:0] ctlRead, ctlNew, tunNew;

    assign pready = 1'b1;
    assign hitCtl = hitsReg(paddr, OFS_CONTROL);
    assign hitTun = hitsReg(paddr, OFS_TUNING);
    assign aliasSel = paddr[3:0];
    assign wrEn = psel && penable && pwrite && clkEn;
    assign pslverr = psel && penable && !(hitCtl || hitTun);

    // selections freeze only under config 1x with the lock set
    assign frozen = cfg_q.switchMonitor[1] && lock_q;
    assign divReady = !st.divisorBusy && !frozen;

    // assembled control word; unused bits stay zero
    always_comb begin
        ctlRead = '0;
        ctlRead[POS_OUT_DIV +: 3] = outDiv_q;
        ctlRead[POS_RC_DIV +: 3] = rcDiv_q;
        ctlRead[POS_SOSC_RDY] = st.soscStable && secondary_osc_enable_q;
        ctlRead[POS_DIV_RDY] = divReady;
        ctlRead[POS_PB_DIV +: 2] = periph_clock_divisor_q;
        ctlRead[POS_PLL_MUL +: 3] = pllMul_q;
        ctlRead[POS_CUR_SRC +: 3] = curSrc_q;
        ctlRead[POS_NEW_SRC +: 3] = newSrc_q;
        ctlRead[POS_LOCK] = lock_q;
        ctlRead[POS_USB_LOCKED] = st.usbPllLock;
        ctlRead[POS_SYS_LOCKED] = st.sysPllLock;
        ctlRead[POS_SLEEP] = sleep_q;
        ctlRead[POS_FAIL] = fail_q;
        ctlRead[POS_USB_RC] = usbRc_q;
        ctlRead[POS_SOSC_EN] = secondary_osc_enable_q;
        ctlRead[POS_SWITCH] = swReq_q;
    end

    // alias arithmetic shared by both registers
    function automatic logic [31:0] applyAlias(input logic [31:0] cur,
                                               input logic [31:0] wd,
                                               input logic [3:0] al);
        logic [31:0] r;
        r = wd;
        unique case (al)
            ALIAS_CLEAR: r = cur & ~wd;
            ALIAS_SET: r = cur | wd;
            ALIAS_INVERT: r = cur ^ wd;
            default: r = wd;
        endcase
        return r;
    endfunction : applyAlias

    assign ctlNew = applyAlias(ctlRead, pwdata, aliasSel);
    assign tunNew = applyAlias({26'h0, tune_q}, pwdata, aliasSel);

    // read data is decoded in the setup phase and registered for the access phase
    logic [31:0] rd_q, rd_d;
    always_comb begin
        rd_d = rd_q;
        if (psel && !penable && !pwrite) begin
            rd_d = '0;
            if (hitCtl) begin
                rd_d = ctlRead;
            end else if (hitTun) begin
                rd_d = 32'(tune_q);
            end
        end
    end
    assign prdata = rd_q;

    // read data register; frozen with the rest while the enable is low
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rd_q <= '0;
        end else if (clkEn) begin
            rd_q <= rd_d;
        end
    end

    // next-state for registers and switch sequencer
    always_comb begin
        outDiv_d = outDiv_q;
        rcDiv_d = rcDiv_q;
        pllMul_d = pllMul_q;
        periph_clock_divisor_d = periph_clock_divisor_q;
        curSrc_d = curSrc_q;
        newSrc_d = newSrc_q;
        lock_d = lock_q;
        sleep_d = sleep_q;
        usbRc_d = usbRc_q;
        secondary_osc_enable_d = secondary_osc_enable_q;
        swReq_d = swReq_q;
        fail_d = fail_q || st.clockFail;
        tune_d = tune_q;
        sw_d = sw_q;
        settle_d = settle_q;
        if (!loaded_q) begin
            // boot values from configuration straps
            outDiv_d = cfgIn.outDiv;
            periph_clock_divisor_d = cfgIn.periph_clock_divisor;
            pllMul_d = cfgIn.pllMul;
            newSrc_d = cfgIn.bootSource;
            curSrc_d = ost_src_t'(cfgIn.bootSource);
            secondary_osc_enable_d = cfgIn.soscEnable;
        end else if (wrEn && hitCtl) begin
            if (!frozen) begin
                outDiv_d = ctlNew[POS_OUT_DIV +: 3];
                pllMul_d = ctlNew[POS_PLL_MUL +: 3];
                newSrc_d = ctlNew[POS_NEW_SRC +: 3];
            end
            if (divReady) begin
                periph_clock_divisor_d = ctlNew[POS_PB_DIV +: 2];
            end
            rcDiv_d = ctlNew[POS_RC_DIV +: 3];
            lock_d = ctlNew[POS_LOCK];
            sleep_d = ctlNew[POS_SLEEP];
            usbRc_d = ctlNew[POS_USB_RC];
            secondary_osc_enable_d = ctlNew[POS_SOSC_EN];
            // software may start a switch but not cancel one in flight
            if (ctlNew[POS_SWITCH] && !frozen) begin
                swReq_d = 1'b1;
            end
            // failure flag clears only by writing zero and no new event
            fail_d = (ctlNew[POS_FAIL] && fail_q) || st.clockFail;
        end else if (wrEn && hitTun) begin
            tune_d = tunNew[TUNE_W-1:0];
        end
        // switch sequencer
        unique case (sw_q)
            SW_IDLE: begin
                if (swReq_q) begin
                    sw_d = SW_WAIT;
                end
            end
            SW_WAIT: begin
                if (st.sourceReady) begin
                    sw_d = SW_SETTLE;
                    settle_d = SWITCH_CYC;
                end
            end
            SW_SETTLE: begin
                if (settle_q > 4'h1) begin
                    settle_d = settle_q - 4'h1;
                end else begin
                    curSrc_d = ost_src_t'(newSrc_q);
                    swReq_d = 1'b0;
                    sw_d = SW_IDLE;
                end
            end
            // the spare state code falls back to idle
            default: begin
                sw_d = SW_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            outDiv_q <= '0;
            rcDiv_q <= RST_RC_DIV;
            pllMul_q <= '0;
            periph_clock_divisor_q <= RST_PB_DIV;
            curSrc_q <= SRC_FRC;
            newSrc_q <= '0;
            lock_q <= 1'b0;
            sleep_q <= 1'b0;
            usbRc_q <= 1'b0;
            secondary_osc_enable_q <= 1'b0;
            swReq_q <= 1'b0;
            fail_q <= 1'b0;
            tune_q <= RST_TUNE;
            sw_q <= SW_IDLE;
            settle_q <= '0;
        end else if (clkEn) begin
            outDiv_q <= outDiv_d;
            rcDiv_q <= rcDiv_d;
            pllMul_q <= pllMul_d;
            periph_clock_divisor_q <= periph_clock_divisor_d;
            curSrc_q <= curSrc_d;
            newSrc_q <= newSrc_d;
            lock_q <= lock_d;
            sleep_q <= sleep_d;
            usbRc_q <= usbRc_d;
            secondary_osc_enable_q <= secondary_osc_enable_d;
            swReq_q <= swReq_d;
            fail_q <= fail_d;
            tune_q <= tune_d;
            sw_q <= sw_d;
            settle_q <= settle_d;
        end
    end

    // decoded settings toward the clock tree, taken from the next values
    // so the registered copy moves on the same edge as the fields
    ost_clk_t clk_q, clk_d;
    always_comb begin
        clk_d.pllOutDivide = divFactor(outDiv_d);
        clk_d.rcDivide = divFactor(rcDiv_d);
        clk_d.periphDivide = 4'(4'h1 << periph_clock_divisor_d);
        clk_d.pllMultiply = mulFactor(pllMul_d);
        clk_d.source = curSrc_d;
        clk_d.usbRcSelect = usbRc_d;
        clk_d.soscEnable = secondary_osc_enable_d;
        clk_d.rcTune = tune_d;
    end

    // registered so the clock tree never sees decode glitches
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            clk_q <= CLK_RST;
        end else if (clkEn) begin
            clk_q <= clk_d;
        end
    end
    assign clkOut = clk_q;

    // wait instruction goes to sleep or idle
    assign enterSleep = waitExec && sleep_q;
    assign enterIdle = waitExec && !sleep_q;
endmodule : ost_oscillator_select_and_tune

// File: ost_oscillator_select_and_tune_tb.sv
// self-checking bench for the oscillator select and tune block
`timescale 1ns/1ps
module ost_oscillator_select_and_tune_tb;
    import ost_pkg::*;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic clkEn = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    ost_cfg_t cfgIn = '{3'h2, 2'h0, 3'h3, 2'h1, 3'h5, 1'b1};
    ost_stat_t statIn = '0;
    logic waitExec = 1'b0;
    ost_clk_t clkOut;
    logic enterSleep;
    logic enterIdle;
    logic [31:0] rd;
    logic err;
    int n_mismatch = 0;
    int tests_run = 0;
    int nWait = 0;
    // divide and multiply factors indexed by field code
    logic [8:0] divTab [8] = '{9'h001, 9'h002, 9'h004, 9'h008,
                               9'h010, 9'h020, 9'h040, 9'h100};
    logic [4:0] mulTab [8] = '{5'h0f, 5'h10, 5'h11, 5'h12,
                               5'h13, 5'h14, 5'h15, 5'h18};

    always #5 core_clk = ~core_clk;

    ost_oscillator_select_and_tune i_ost_oscillator_select_and_tune (
        .core_clk(core_clk), .rst(rst), .clkEn(clkEn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cfgIn(cfgIn), .statIn(statIn),
        .waitExec(waitExec), .clkOut(clkOut), .enterSleep(enterSleep),
        .enterIdle(enterIdle));

    task automatic tally_and_finish();
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : tally_and_finish

    task automatic check(input string nm, input logic [31:0] seen,
                         input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    // one apb transfer; the idle cycle after it keeps psel from
    // being driven twice in one time step
    task automatic xfer(input logic [11:0] a, input logic w,
                        input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask : xfer

    // write, read back the base register, compare the masked word
    task automatic wchk(input logic [11:0] a, input logic [31:0] d,
                        input logic [31:0] m, input logic [31:0] e);
        xfer(a, 1'b1, d);
        xfer(a & 12'hff0, 1'b0, 32'h0);
        check($sformatf("reg %h", a), rd & m, e & m);
    endtask : wchk

    task automatic do_reset(input logic [1:0] mon);
        cfgIn.switchMonitor <= mon;
        rst <= 1'b1;
        repeat (6) @(posedge core_clk);
        rst <= 1'b0;
        repeat (2) @(posedge core_clk);
    endtask : do_reset

    function automatic logic [31:0] cw(input logic [2:0] od, rc,
        input logic [1:0] pb, input logic [2:0] ml, ns,
        input logic [7:0] lo);
        return {2'b00, od, rc, 3'b000, pb, ml, 5'h00, ns, lo};
    endfunction : cw

    initial begin : watchdog
        #100000;
        n_mismatch++;
        tally_and_finish();
    end

    initial begin : main
        do_reset(2'h0);
        xfer(OFS_CONTROL, 1'b0, 32'h0);
        check("rst ctl", rd & CONTROL_WMASK,
              cw(3'h3, 3'h1, 2'h1, 3'h5, 3'h2, 8'h02));
        check("cur", rd[14:12], SRC_PRI);
        check("divrdy", rd[21], 1'b1);
        xfer(OFS_TUNING, 1'b0, 32'h0);
        check("tune rst", rd, 32'h0);
        // every divider and multiplier code
        for (int c = 0; c < 8; c++) begin
            xfer(OFS_CONTROL, 1'b1,
                 cw(3'(c), 3'(c), 2'(c), 3'(c), 3'h2, 8'h02));
            check("od", clkOut.pllOutDivide, divTab[c]);
            check("rc", clkOut.rcDivide, divTab[c]);
            check("pb", clkOut.periphDivide, divTab[c & 3]);
            check("ml", clkOut.pllMultiply, mulTab[c]);
        end
        wchk(OFS_TUNING, 32'hffffffdf, '1, 32'h1f);
        wchk(OFS_TUNING | ALIAS_SET, 32'h20, '1, 32'h3f);
        wchk(OFS_TUNING | ALIAS_CLEAR, 32'h0f, '1, 32'h30);
        wchk(OFS_TUNING | ALIAS_INVERT, 32'h3c, '1, 32'h0c);
        wchk(OFS_TUNING, 32'h20, '1, 32'h20);
        check("tune", clkOut.rcTune, 6'h20);
        // no state moves while the clock enable is low
        clkEn <= 1'b0;
        xfer(OFS_TUNING, 1'b1, 32'h11);
        clkEn <= 1'b1;
        xfer(OFS_TUNING, 1'b0, 32'h0);
        check("hold tune", rd, 32'h20);
        xfer(OFS_STATUS_EXT, 1'b0, 32'h0);
        check("unmapped", rd, 32'h0);
        check("slverr", err, 1'b1);
        // lock bit has no effect while monitoring is enabled
        xfer(OFS_CONTROL, 1'b1, cw(3'h0, 3'h1, 2'h3, 3'h0, 3'h2, 8'h82));
        wchk(OFS_CONTROL, cw(3'h4, 3'h1, 2'h3, 3'h0, 3'h2, 8'h82),
             CONTROL_WMASK, cw(3'h4, 3'h1, 2'h3, 3'h0, 3'h2, 8'h82));
        // busy divisor refuses writes, status synchroniser needs 4 edges
        statIn.divisorBusy <= 1'b1;
        repeat (6) @(posedge core_clk);
        wchk(OFS_CONTROL, cw(3'h4, 3'h1, 2'h0, 3'h0, 3'h2, 8'h82),
             CONTROL_WMASK, cw(3'h4, 3'h1, 2'h3, 3'h0, 3'h2, 8'h82));
        check("busy rdy", rd[21], 1'b0);
        statIn <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
        repeat (6) @(posedge core_clk);
        xfer(OFS_CONTROL, 1'b0, 32'h0);
        check("flags", {rd[22], rd[6:5], rd[3]}, 4'hf);
        statIn <= '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
        repeat (6) @(posedge core_clk);
        xfer(OFS_CONTROL, 1'b0, 32'h0);
        check("sticky", {rd[22], rd[6:5], rd[3]}, 4'h9);
        // sleep, usb rc and oscillator enable through set and clear
        xfer(OFS_CONTROL | ALIAS_SET, 1'b1, 32'h14);
        waitExec <= 1'b1;
        @(posedge core_clk);
        check("sleep", {enterSleep, enterIdle}, 2'h2);
        check("usbrc", clkOut.usbRcSelect, 1'b1);
        xfer(OFS_CONTROL | ALIAS_CLEAR, 1'b1, 32'h12);
        check("idle", {enterSleep, enterIdle}, 2'h1);
        check("sosc off", clkOut.soscEnable, 1'b0);
        xfer(OFS_CONTROL, 1'b0, 32'h0);
        check("sosc rdy", rd[22], 1'b0);
        waitExec <= 1'b0;
        // source switch held until the oscillator reports ready
        xfer(OFS_CONTROL, 1'b1, cw(3'h4, 3'h1, 2'h3, 3'h0, 3'h1, 8'h03));
        xfer(OFS_CONTROL, 1'b0, 32'h0);
        check("pending", {rd[14:12], rd[0]}, {3'h2, 1'b1});
        statIn.sourceReady <= 1'b1;
        for (nWait = 0; nWait < 60 && clkOut.source !== SRC_FRC_PLL;
             nWait++) begin
            @(posedge core_clk);
        end
        // four synchroniser edges, the ready step, the settle count, one look
        check("settle", nWait, 32'(SWITCH_CYC) + 32'h6);
        xfer(OFS_CONTROL, 1'b0, 32'h0);
        check("switched", {rd[14:12], rd[0]}, {3'h1, 1'b0});
        // frozen selections once switching is disabled
        do_reset(2'h2);
        xfer(OFS_CONTROL | ALIAS_SET, 1'b1, 32'h80);
        xfer(OFS_CONTROL, 1'b1, cw(3'h0, 3'h1, 2'h0, 3'h0, 3'h4, 8'h83));
        xfer(OFS_CONTROL, 1'b0, 32'h0);
        check("frozen", {rd[29:27], rd[20:16], rd[10:8], rd[0], rd[21]},
              {3'h3, 2'h1, 3'h5, 3'h2, 2'h0});
        check("frz od", clkOut.pllOutDivide, 9'h008);
        tally_and_finish();
    end
endmodule : ost_oscillator_select_and_tune_tb

// File: ost_pkg.sv
// package for the oscillator select and tune block
package ost_pkg;
    // register byte offsets (register base plus alias)
    localparam logic [11:0] OFS_CONTROL = 12'h000;
    localparam logic [11:0] OFS_TUNING = 12'h010;
    localparam logic [11:0] OFS_STATUS_EXT = 12'h020;
    localparam logic [3:0] ALIAS_WRITE = 4'h0;
    localparam logic [3:0] ALIAS_CLEAR = 4'h4;
    localparam logic [3:0] ALIAS_SET = 4'h8;
    localparam logic [3:0] ALIAS_INVERT = 4'hc;

    // control register field positions
    localparam int POS_OUT_DIV = 27;
    localparam int POS_RC_DIV = 24;
    localparam int POS_SOSC_RDY = 22;
    localparam int POS_DIV_RDY = 21;
    localparam int POS_PB_DIV = 19;
    localparam int POS_PLL_MUL = 16;
    localparam int POS_CUR_SRC = 12;
    localparam int POS_NEW_SRC = 8;
    localparam int POS_LOCK = 7;
    localparam int POS_USB_LOCKED = 6;
    localparam int POS_SYS_LOCKED = 5;
    localparam int POS_SLEEP = 4;
    localparam int POS_FAIL = 3;
    localparam int POS_USB_RC = 2;
    localparam int POS_SOSC_EN = 1;
    localparam int POS_SWITCH = 0;
    localparam int TUNE_W = 6;

    // writable bits of the control register
    localparam logic [31:0] CONTROL_WMASK = 32'h3f1f079f;
    localparam logic [31:0] TUNING_WMASK = 32'h0000003f;

    // reset values not taken from configuration, except the periph divisor, which the straps replace
    localparam logic [2:0] RST_RC_DIV = 3'h1;
    localparam logic [1:0] RST_PB_DIV = 2'h3;
    localparam logic [5:0] RST_TUNE = 6'h00;
    // cycles the device takes to settle a source change
    localparam int SWITCH_NS = 100;
    localparam int CLK_NS = 10;
    localparam logic [3:0] SWITCH_CYC = 4'((SWITCH_NS + CLK_NS - 1) / CLK_NS);

    typedef enum logic [2:0] {
        SRC_FRC = 3'h0,
        SRC_FRC_PLL = 3'h1,
        SRC_PRI = 3'h2,
        SRC_PRI_PLL = 3'h3,
        SRC_SEC = 3'h4,
        SRC_LOW_POWER_RC_OSC = 3'h5,
        SRC_FRC_16 = 3'h6,
        SRC_FRC_DIV = 3'h7
    } ost_src_t;

    // configuration straps sampled after reset
    typedef struct packed {
        logic [2:0] bootSource;
        logic [1:0] switchMonitor;
        logic [2:0] outDiv;
        logic [1:0] periph_clock_divisor;
        logic [2:0] pllMul;
        logic soscEnable;
    } ost_cfg_t;

    // settings driven to the clock tree
    typedef struct packed {
        logic [8:0] pllOutDivide;
        logic [8:0] rcDivide;
        logic [3:0] periphDivide;
        logic [4:0] pllMultiply;
        ost_src_t source;
        logic usbRcSelect;
        logic soscEnable;
        logic [5:0] rcTune;
    } ost_clk_t;

    // analog status reported by the oscillators
    typedef struct packed {
        logic soscStable;
        logic usbPllLock;
        logic sysPllLock;
        logic clockFail;
        logic divisorBusy;
        logic sourceReady;
    } ost_stat_t;
endpackage : ost_pkg
